// File: design/lsae_consts.svh
// register offsets, field positions, reset values and link encodings for the special-address encoder
// assumes inclusion by bare name from design files that also use lsae_pkg
`ifndef LSAE_CONSTS_SVH
`define LSAE_CONSTS_SVH

// apb word offsets
`define LSAE_CTRL_OFS 8'h00
`define LSAE_TXA_OFS 8'h04
`define LSAE_TXB_OFS 8'h08
`define LSAE_GO_OFS 8'h0c
`define LSAE_RXLO_OFS 8'h10
`define LSAE_RXHI_OFS 8'h14
`define LSAE_ISTAT_OFS 8'h18
`define LSAE_IMASK_OFS 8'h1c
`define LSAE_LINE_OFS 8'h20
`define LSAE_SM_OFS 8'h24

// reset values
`define LSAE_CTRL_RST 3'h0
`define LSAE_MASK_RST 8'h00
`define LSAE_TXA_RST 32'h0000_0000
`define LSAE_SB_RST 4'hf

// control bits
`define LSAE_CTRL_STOP 0
`define LSAE_CTRL_REQ 1
`define LSAE_CTRL_TXEN 2

// interrupt status bits
`define LSAE_IS_TXDONE 0
`define LSAE_IS_CFG 1
`define LSAE_IS_SPECIAL 2
`define LSAE_IS_INTR 3
`define LSAE_IS_EOI 4
`define LSAE_IS_SM 5
`define LSAE_IS_ERR 6
`define LSAE_IS_LINE 7

// reserved-address prefixes, special-cycle low half and eoi message code
`define LSAE_CFG0_PREFIX 16'hfdfe
`define LSAE_CFG1_PREFIX 16'hfdff
`define LSAE_SPECIAL_LOW 16'hff00
`define LSAE_INTR_PREFIX 16'hfdf8
`define LSAE_SM_PREFIX 20'hfdf91
`define LSAE_EOI_MSG 3'h7

// system-management command types from the processor
`define LSAE_SM_FLOAT_ERROR_WIRE 4'h2
`define LSAE_SM_SHUTDOWN 4'h4
`define LSAE_SM_HALT 4'h5
`define LSAE_SM_STOPGRANT 4'h6
`define LSAE_SM_VIDFID 4'h7
`define LSAE_SM_WRITEBACK_INVALIDATE 4'h8
`define LSAE_SM_CACHE_INVALIDATE 4'h9
`define LSAE_SM_MGMT_INTERRUPT_ACK_WIRE 4'ha

// transmit bit-time split into quarter-period phases
`define LSAE_TX_LAST_PHASE 2'h3
`define LSAE_TX_RISE_PHASE 2'h1

`endif

// File: design/lsae_pkg.sv
// types shared by the special-address encoder modules
// assumes nothing beyond a systemverilog elaborator
package lsae_pkg;

  typedef enum logic [2:0] {
    LSAE_K_CFG0 = 3'b000,
    LSAE_K_CFG1 = 3'b001,
    LSAE_K_SPECIAL = 3'b010,
    LSAE_K_INTR = 3'b011,
    LSAE_K_SYSMGMT = 3'b100,
    LSAE_K_EOI = 3'b101,
    LSAE_K_NONE = 3'b110
  } lsae_kind_type;

  typedef enum logic {
    LSAE_TX_IDLE = 1'b0,
    LSAE_TX_SEND = 1'b1
  } lsae_tx_state_type;

endpackage : lsae_pkg

// File: design/lsae_rx_if.sv
// carrier between receive capture and the core
// assumes both ends run on mclk
`timescale 1ns/10ps
interface lsae_rx_if;
  logic [39:0] word;
  logic valid;
  logic frame_err;
  modport cap (output word, output valid, output frame_err);
  modport core (input word, input valid, input frame_err);
endinterface : lsae_rx_if

// File: design/lsae_rx_capture.sv
// receive capture: samples the incoming link by its forwarded clock, rebuilds 40-bit addresses
// assumes the forwarded clock is far slower than mclk so synced edges can be found
`timescale 1ns/10ps
module lsae_rx_capture #(
  parameter int CAD_W = 8,
  parameter int BEATS = 5
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [CAD_W-1:0] cad_i,
  input wire logic ctl_i,
  input wire logic fclk_i,
  lsae_rx_if.cap rx
);
  localparam int SW = BEATS * CAD_W;
  logic [CAD_W+1:0] meta_q;
  logic [CAD_W+1:0] sync_q;
  logic clk_prev_q;
  logic [SW-1:0] buf_q;
  logic [5:0] cnt_q;
  logic [39:0] word_q;
  logic valid_q;
  logic err_q;
  wire logic edge_w = sync_q[CAD_W+1] & ~clk_prev_q;
  wire logic [SW-1:0] nbuf_w = {sync_q[CAD_W-1:0], buf_q[SW-1:CAD_W]};

  // same delay on clock, control and data keeps their phase relation
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      meta_q <= {fclk_i, ctl_i, cad_i};
      sync_q <= meta_q;
      clk_prev_q <= sync_q[CAD_W+1];
    end
  end

  // sampled on received clock edges, handed to mclk domain as a word
  always_ff @(posedge mclk_i) begin // see R11
    if (reset_i) begin
      buf_q <= '0;
      cnt_q <= 6'h00;
      word_q <= 40'h0;
      valid_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      err_q <= 1'b0;
      if (edge_w && sync_q[CAD_W]) begin
        buf_q <= nbuf_w;
        if (cnt_q == 6'(BEATS - 1)) begin
          cnt_q <= 6'h00;
          word_q <= nbuf_w[39:0];
          valid_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end else if (!sync_q[CAD_W] && cnt_q != 6'h00) begin
        // clock stops between frames, so a cut frame shows only as control falling
        err_q <= 1'b1;
        cnt_q <= 6'h00;
      end
    end
  end

  assign rx.word = word_q;
  assign rx.valid = valid_q;
  assign rx.frame_err = err_q;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  rx_word_edge_a: assert property (valid_q |-> $past(edge_w) && $past(sync_q[CAD_W])) // see R11
    else $error("word completed without a received clock edge under control");
  rx_count_bound_a: assert property (cnt_q < 6'(BEATS)) // see R9
    else $error("beat count ran past the packet length");
endmodule : lsae_rx_capture

// File: design/lsae_top.sv
// special-address encoder and link framer: apb registers, transmit framer, receive decoder, sideband
// assumes an apb master on mclk; link pins and sideband pins are asynchronous to mclk
//
// Contract
// R1 - config prefix fdfe current bus, fdff numbered
// R2 - bus, device, function, register fields; bits1:0 zero
// R3 - foreign special cycle: numbered config, low ff00
// R4 - interrupt/eoi prefix fdf8, vector, destination, mode bits
// R5 - system management prefix fdf91, command, payload
// R6 - command 2 float error, 4-6 shutdown/halt/grant
// R7 - 7 voltage_frequency_id, 8 writeback_invalidate, 9 cache_invalidate, 10 ack
// R8 - payload 3:1 carries management action field
// R9 - two unidirectional sets: data, control, clocks
// R10 - forwarded clock lags data by quarter period
// R11 - sample by received clock, pass to domain
// R12 - power good input accepted
// R13 - active-low reset input accepted
// R14 - link stop/request sidebands signal power events
// R15 - reserved fields sent zero, ignored on receive
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "lsae_consts.svh"
module lsae_top #(
  parameter int CAD_W = 8,
  parameter int CLK_W = (CAD_W > 8) ? CAD_W / 8 : 1
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic [CAD_W-1:0] cmd_addr_data_out_o,
  output logic control_line_out_o,
  output logic [CLK_W-1:0] forwarded_clock_out_o,
  input wire logic [CAD_W-1:0] cmd_addr_data_in_i,
  input wire logic control_line_in_i,
  input wire logic forwarded_clock_in_i,
  input wire logic power_good_i,
  input wire logic link_reset_n_i,
  input wire logic link_stop_n_i,
  output logic link_stop_n_o,
  output logic link_stop_n_oe_o,
  input wire logic link_request_n_i,
  output logic link_request_n_o,
  output logic link_request_n_oe_o
);
  localparam int BEATS = (40 + CAD_W - 1) / CAD_W;
  localparam int SW = BEATS * CAD_W;

  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;
  logic [2:0] ctrl_q;
  logic [31:0] txa_q, txb_q;
  logic [7:0] mask_q, st_q, set_w;
  logic [3:0] sb_meta_q, sb_sync_q, sb_prev_q;
  lsae_pkg::lsae_tx_state_type state_q;
  lsae_pkg::lsae_kind_type kind_q, rx_kind_q;
  logic [1:0] phase_q;
  logic [5:0] beat_q;
  logic [SW-1:0] sh_q;
  logic [CAD_W-1:0] cad_q;
  logic ctl_q, fclk_q, done_q, stop_oe_q, req_oe_q;
  logic [39:0] rx_addr_q;
  logic [3:0] sm_cmd_q;
  logic float_error_wire_q, mgmt_interrupt_ack_wire_q;
  logic [2:0] action_q;
  logic [31:0] rdata_d;
  logic hit_d;
  lsae_rx_if rxif ();

  wire logic acc_w = psel_i & penable_i;
  wire logic wr_w = acc_w & pready_q & pwrite_i & ~pslverr_q;
  wire logic start_w = wr_w && paddr_i == `LSAE_GO_OFS && ctrl_q[`LSAE_CTRL_TXEN]
    && state_q == lsae_pkg::LSAE_TX_IDLE && sb_sync_q[1];
  wire lsae_pkg::lsae_kind_type rxk_w = dec_kind(rxif.word);

  function automatic logic [39:0] enc_addr(input lsae_pkg::lsae_kind_type k, input logic [31:0] a,
                                           input logic [31:0] b);
    logic [39:0] r;
    r = 40'h0;
    case (k)
      lsae_pkg::LSAE_K_CFG0: r = {`LSAE_CFG0_PREFIX, 8'h00, a[12:8], a[18:16], a[29:24], 2'b00}; // see R1
      lsae_pkg::LSAE_K_CFG1: r = {`LSAE_CFG1_PREFIX, a[7:0], a[12:8], a[18:16], a[29:24], 2'b00}; // see R2
      lsae_pkg::LSAE_K_SPECIAL: r = {`LSAE_CFG1_PREFIX, a[7:0], `LSAE_SPECIAL_LOW}; // see R3
      lsae_pkg::LSAE_K_INTR: r = {`LSAE_INTR_PREFIX, b[7:0], b[15:8], b[21], b[16], b[17], b[20:18], 2'b00}; // see R4
      lsae_pkg::LSAE_K_SYSMGMT: r = {`LSAE_SM_PREFIX, 4'h0, b[27:24], b[31:28], 8'h00}; // see R5
      default: r = 40'h0;
    endcase
    return r;
  endfunction : enc_addr

  // reserved bits below the prefixes are not compared
  function automatic lsae_pkg::lsae_kind_type dec_kind(input logic [39:0] w); // see R15
    lsae_pkg::lsae_kind_type k;
    k = lsae_pkg::LSAE_K_NONE;
    if (w[39:24] == `LSAE_CFG0_PREFIX) k = lsae_pkg::LSAE_K_CFG0;
    else if (w[39:24] == `LSAE_CFG1_PREFIX)
      k = (w[15:0] == `LSAE_SPECIAL_LOW) ? lsae_pkg::LSAE_K_SPECIAL : lsae_pkg::LSAE_K_CFG1;
    else if (w[39:24] == `LSAE_INTR_PREFIX)
      k = (w[4:2] == `LSAE_EOI_MSG) ? lsae_pkg::LSAE_K_EOI : lsae_pkg::LSAE_K_INTR;
    else if (w[39:20] == `LSAE_SM_PREFIX) k = lsae_pkg::LSAE_K_SYSMGMT;
    return k;
  endfunction : dec_kind

  // sideband pins: power good, link reset, stop, request
  always_ff @(posedge mclk_i) begin // see R12
    if (reset_i) begin
      // idle pin levels, so leaving reset shows no false pin change
      sb_meta_q <= `LSAE_SB_RST;
      sb_sync_q <= `LSAE_SB_RST;
      sb_prev_q <= `LSAE_SB_RST;
    end else begin
      sb_meta_q <= {link_request_n_i, link_stop_n_i, link_reset_n_i, power_good_i}; // see R13
      sb_sync_q <= sb_meta_q;
      sb_prev_q <= sb_sync_q;
    end
  end

  // apb: one wait state, answer registered
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc_w & ~pready_q;
      pslverr_q <= acc_w & ~pready_q & ~hit_d;
      if (acc_w && !pready_q) prdata_q <= pwrite_i ? 32'h0 : rdata_d;
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    hit_d = 1'b1;
    case (paddr_i)
      `LSAE_CTRL_OFS: rdata_d = {29'h0, ctrl_q};
      `LSAE_TXA_OFS: rdata_d = txa_q;
      `LSAE_TXB_OFS: rdata_d = txb_q;
      `LSAE_GO_OFS: rdata_d = {29'h0, kind_q};
      `LSAE_RXLO_OFS: rdata_d = rx_addr_q[31:0];
      `LSAE_RXHI_OFS: rdata_d = {21'h0, rx_kind_q, rx_addr_q[39:32]};
      `LSAE_ISTAT_OFS: rdata_d = {24'h0, st_q};
      `LSAE_IMASK_OFS: rdata_d = {24'h0, mask_q};
      `LSAE_LINE_OFS: rdata_d = {27'h0, state_q == lsae_pkg::LSAE_TX_SEND, sb_sync_q};
      `LSAE_SM_OFS: rdata_d = {21'h0, action_q, 2'b00, mgmt_interrupt_ack_wire_q, float_error_wire_q, sm_cmd_q};
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_q <= `LSAE_CTRL_RST;
      txa_q <= `LSAE_TXA_RST;
      txb_q <= `LSAE_TXA_RST;
      mask_q <= `LSAE_MASK_RST;
    end else if (wr_w) begin
      if (paddr_i == `LSAE_CTRL_OFS) ctrl_q <= pwdata_i[2:0];
      if (paddr_i == `LSAE_TXA_OFS) txa_q <= pwdata_i;
      if (paddr_i == `LSAE_TXB_OFS) txb_q <= pwdata_i;
      if (paddr_i == `LSAE_IMASK_OFS) mask_q <= pwdata_i[7:0];
    end
  end

  // sticky events; a set in the clearing cycle survives
  always_comb begin
    set_w = 8'h00;
    set_w[`LSAE_IS_TXDONE] = done_q;
    set_w[`LSAE_IS_CFG] = rxif.valid && (rxk_w == lsae_pkg::LSAE_K_CFG0 || rxk_w == lsae_pkg::LSAE_K_CFG1);
    set_w[`LSAE_IS_SPECIAL] = rxif.valid && rxk_w == lsae_pkg::LSAE_K_SPECIAL;
    set_w[`LSAE_IS_INTR] = rxif.valid && rxk_w == lsae_pkg::LSAE_K_INTR;
    set_w[`LSAE_IS_EOI] = rxif.valid && rxk_w == lsae_pkg::LSAE_K_EOI;
    set_w[`LSAE_IS_SM] = rxif.valid && rxk_w == lsae_pkg::LSAE_K_SYSMGMT;
    set_w[`LSAE_IS_ERR] = rxif.frame_err || (rxif.valid && rxk_w == lsae_pkg::LSAE_K_NONE);
    set_w[`LSAE_IS_LINE] = sb_sync_q != sb_prev_q; // see R14
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      st_q <= (st_q & ~((wr_w && paddr_i == `LSAE_ISTAT_OFS) ? pwdata_i[7:0] : 8'h00)) | set_w;
      irq_q <= |(st_q & mask_q);
    end
  end

  // received message latch and processor message decode
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rx_addr_q <= 40'h0;
      rx_kind_q <= lsae_pkg::LSAE_K_NONE;
      sm_cmd_q <= 4'h0;
      float_error_wire_q <= 1'b0;
      mgmt_interrupt_ack_wire_q <= 1'b0;
      action_q <= 3'h0;
    end else if (rxif.valid) begin
      rx_addr_q <= rxif.word;
      rx_kind_q <= rxk_w;
      if (rxk_w == lsae_pkg::LSAE_K_SYSMGMT) begin
        sm_cmd_q <= rxif.word[15:12]; // see R7
        if (rxif.word[15:12] == `LSAE_SM_FLOAT_ERROR_WIRE) float_error_wire_q <= rxif.word[8]; // see R6
        if (rxif.word[15:12] == `LSAE_SM_MGMT_INTERRUPT_ACK_WIRE) mgmt_interrupt_ack_wire_q <= rxif.word[8]; // see R7
        if (rxif.word[15:12] == `LSAE_SM_STOPGRANT) action_q <= rxif.word[11:9]; // see R8
      end
    end
  end

  // quarter-phase counter: data moves at phase 0, clock rises at phase 1
  always_ff @(posedge mclk_i) begin // see R10
    if (reset_i) begin
      phase_q <= 2'h0;
      fclk_q <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h0) fclk_q <= 1'b1;
      if (phase_q == 2'h2) fclk_q <= 1'b0;
    end
  end

  // transmit framer; link reset abandons a packet
  always_ff @(posedge mclk_i) begin // see R9
    if (reset_i || !sb_sync_q[1]) begin
      state_q <= lsae_pkg::LSAE_TX_IDLE;
      kind_q <= lsae_pkg::LSAE_K_CFG0;
      sh_q <= '0;
      beat_q <= 6'h00;
      cad_q <= '0;
      ctl_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_w) begin
        state_q <= lsae_pkg::LSAE_TX_SEND;
        kind_q <= lsae_pkg::lsae_kind_type'(pwdata_i[2:0]);
        sh_q <= SW'(enc_addr(lsae_pkg::lsae_kind_type'(pwdata_i[2:0]), txa_q, txb_q));
        beat_q <= 6'h00;
      end else if (state_q == lsae_pkg::LSAE_TX_SEND && phase_q == `LSAE_TX_LAST_PHASE) begin
        if (beat_q == 6'(BEATS)) begin
          cad_q <= '0; // see R15
          ctl_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= lsae_pkg::LSAE_TX_IDLE;
        end else begin
          cad_q <= sh_q[CAD_W-1:0];
          ctl_q <= 1'b1;
          sh_q <= sh_q >> CAD_W;
          beat_q <= beat_q + 6'h01;
        end
      end
    end
  end

  // open-drain sidebands: pull low while software asks
  always_ff @(posedge mclk_i) begin // see R14
    if (reset_i) begin
      stop_oe_q <= 1'b0;
      req_oe_q <= 1'b0;
    end else begin
      stop_oe_q <= ctrl_q[`LSAE_CTRL_STOP];
      req_oe_q <= ctrl_q[`LSAE_CTRL_REQ];
    end
  end

  lsae_rx_capture #(.CAD_W(CAD_W), .BEATS(BEATS)) u_rx (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .cad_i(cmd_addr_data_in_i),
    .ctl_i(control_line_in_i),
    .fclk_i(forwarded_clock_in_i),
    .rx(rxif.cap)
  );

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign irq_o = irq_q;
  assign cmd_addr_data_out_o = cad_q;
  assign control_line_out_o = ctl_q;
  assign forwarded_clock_out_o = {CLK_W{fclk_q}};
  assign link_stop_n_o = 1'b0;
  assign link_stop_n_oe_o = stop_oe_q;
  assign link_request_n_o = 1'b0;
  assign link_request_n_oe_o = req_oe_q;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  cfg_prefix_a: assert property ($rose(state_q) && kind_q == lsae_pkg::LSAE_K_CFG0 |-> // see R1
    sh_q[39:24] == `LSAE_CFG0_PREFIX && sh_q[23:16] == 8'h00) else $error("current-bus config prefix wrong");
  cfg_low_bits_a: assert property ($rose(state_q) && kind_q == lsae_pkg::LSAE_K_CFG1 |-> // see R2
    sh_q[39:24] == `LSAE_CFG1_PREFIX && sh_q[1:0] == 2'b00 && sh_q[23:16] == $past(txa_q[7:0]))
    else $error("numbered config address wrong");
  special_low_a: assert property ($rose(state_q) && kind_q == lsae_pkg::LSAE_K_SPECIAL |-> // see R3
    sh_q[15:0] == `LSAE_SPECIAL_LOW) else $error("special cycle low half wrong");
  intr_prefix_a: assert property ($rose(state_q) && kind_q == lsae_pkg::LSAE_K_INTR |-> // see R4
    sh_q[39:24] == `LSAE_INTR_PREFIX && sh_q[6] == $past(txb_q[16])) else $error("interrupt address wrong");
  sm_prefix_a: assert property ($rose(state_q) && kind_q == lsae_pkg::LSAE_K_SYSMGMT |-> // see R5
    sh_q[39:20] == `LSAE_SM_PREFIX && sh_q[19:16] == 4'h0 && sh_q[1:0] == 2'b00)
    else $error("system management address wrong");
  data_phase_a: assert property ($changed(cad_q) |-> phase_q == 2'h0) // see R10
    else $error("link data moved off the bit boundary");
  clock_lag_a: assert property ($rose(fclk_q) |-> phase_q == `LSAE_TX_RISE_PHASE) // see R10
    else $error("forwarded clock not a quarter behind data");
  ctl_frame_a: assert property ($rose(ctl_q) |-> ctl_q [*4] ##0 $stable(ctl_q)) // see R9
    else $error("control line shorter than a bit time");
  stop_drive_a: assert property ($rose(ctrl_q[`LSAE_CTRL_STOP]) |=> stop_oe_q && !link_stop_n_o) // see R14
    else $error("link stop not pulled low");
  irq_level_a: assert property (|(st_q & mask_q) |=> irq_q) else $error("unmasked event without interrupt");
  sm_float_error_wire_a: assert property (rxif.valid && rxk_w == lsae_pkg::LSAE_K_SYSMGMT // see R6
    && rxif.word[15:12] == `LSAE_SM_FLOAT_ERROR_WIRE |=> float_error_wire_q == $past(rxif.word[8])) else $error("float error wire not latched");
endmodule : lsae_top

// File: verification/lsae_peer.sv
// link peer model: far transmitter on the receive pins, frame catcher on the transmit pins
// assumes 8 lanes and a forwarded clock much slower than mclk
`timescale 1ns/10ps
module lsae_peer (
  input wire logic mclk_i,
  input wire logic [7:0] cad_i,
  input wire logic ctl_i,
  input wire logic fclk_i,
  output logic [7:0] cad_o,
  output logic ctl_o,
  output logic fclk_o,
  output logic [39:0] word_o,
  output int frames_o,
  output int skew_o
);
  logic fclk_q = 1'b0;
  logic ctl_q = 1'b0;
  logic [7:0] cad_q = 8'h00;
  logic [39:0] acc_q = 40'h0;
  int beat_q = 0;

  initial begin
    cad_o = 8'h00;
    ctl_o = 1'b0;
    fclk_o = 1'b0;
    word_o = 40'h0;
    frames_o = 0;
    skew_o = 0;
  end

  // lanes must stay still while the forwarded clock is high
  always @(posedge mclk_i) begin
    fclk_q <= fclk_i;
    ctl_q <= ctl_i;
    cad_q <= cad_i;
    if (fclk_i && cad_i != cad_q) skew_o <= skew_o + 1;
    if (fclk_i && !fclk_q && ctl_i) begin
      acc_q[beat_q*8 +: 8] <= cad_i;
      beat_q <= beat_q + 1;
    end
    if (ctl_q && !ctl_i) begin
      word_o <= acc_q;
      frames_o <= frames_o + 1;
      beat_q <= 0;
    end
  end

  // clock stands still between frames; lanes show garbage once released
  task automatic send(input logic [39:0] a, input int nb = 5);
    for (int k = 0; k < nb; k++) begin
      cad_o = a[k*8 +: 8];
      ctl_o = 1'b1;
      #50 fclk_o = 1'b1;
      #100 fclk_o = 1'b0;
      #50;
    end
    ctl_o = 1'b0;
    cad_o = ~cad_o;
  endtask : send
endmodule : lsae_peer

// File: verification/test_lsae_top.sv
// self-checking bench: apb registers, transmit framing, receive decode, sideband pins
// assumes the peer model on the link pins and the default 8 lanes
`timescale 1ns/10ps
module test_lsae_top;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic irq_o;
  logic [7:0] cad_out;
  logic ctl_out;
  logic [0:0] fclk_out;
  logic [7:0] cad_in;
  logic ctl_in;
  logic fclk_in;
  logic power_good_i = 1'b1;
  logic link_reset_n_i = 1'b1;
  logic stop_o;
  logic stop_oe;
  logic req_o;
  logic req_oe;
  logic [39:0] peer_word;
  int peer_frames;
  int peer_skew;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;
  // board pull-ups on the open-drain sideband pins
  wire stop_pin = (stop_oe === 1'b1) ? stop_o : 1'b1;
  wire req_pin = (req_oe === 1'b1) ? req_o : 1'b1;

  lsae_top i_lsae_top (.mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .irq_o, .cmd_addr_data_out_o(cad_out), .control_line_out_o(ctl_out),
    .forwarded_clock_out_o(fclk_out), .cmd_addr_data_in_i(cad_in), .control_line_in_i(ctl_in),
    .forwarded_clock_in_i(fclk_in), .power_good_i, .link_reset_n_i, .link_stop_n_i(stop_pin),
    .link_stop_n_o(stop_o), .link_stop_n_oe_o(stop_oe), .link_request_n_i(req_pin),
    .link_request_n_o(req_o), .link_request_n_oe_o(req_oe));
  lsae_peer i_lsae_peer (.mclk_i, .cad_i(cad_out), .ctl_i(ctl_out), .fclk_i(fclk_out[0]), .cad_o(cad_in),
    .ctl_o(ctl_in), .fclk_o(fclk_in), .word_o(peer_word), .frames_o(peer_frames), .skew_o(peer_skew));

  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    logic [31:0] r;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk({7'h0, e, rd}, {8'h0, x});
  endtask : rdc

  task automatic wait_stat(input int b);
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h18, 32'h0, rd, e);
      n++;
    end while (rd[b] !== 1'b1 && n < 30);
    chk(rd[b], 1'b1);
  endtask : wait_stat

  task automatic tx_one(input logic [2:0] k, input logic [39:0] x);
    int f;
    f = peer_frames;
    wr(8'h0c, {29'h0, k});
    for (int n = 0; n < 200 && peer_frames == f; n++) @(posedge mclk_i);
    chk(peer_word, x);
  endtask : tx_one

  task automatic t_reset();
    logic e;
    rdc(8'h00, 32'h0);
    rdc(8'h18, 32'h0);
    rdc(8'h1c, 32'h0);
    rdc(8'h20, 32'h0f);
    apb(1'b0, 8'h40, 32'h0, rd, e);
    chk({7'h0, e, rd}, {8'h1, 32'h0});
    chk({ctl_out, cad_out}, 9'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx();
    wr(8'h00, 32'h4);
    wr(8'h04, 32'h2d05_135a);
    wr(8'h08, 32'hb615_3ca7);
    tx_one(3'h0, {16'hfdfe, 8'h00, 16'h9db4});
    chk(irq_o, 1'b0);
    wr(8'h1c, 32'h1);
    repeat (3) @(posedge mclk_i);
    chk(irq_o, 1'b1);
    wr(8'h18, 32'h1);
    repeat (3) @(posedge mclk_i);
    chk(irq_o, 1'b0);
    tx_one(3'h1, {16'hfdff, 8'h5a, 16'h9db4});
    tx_one(3'h2, {16'hfdff, 8'h5a, 16'hff00});
    tx_one(3'h3, {16'hfdf8, 8'ha7, 8'h3c, 8'h54});
    wr(8'h08, 32'h001c_00a7);
    tx_one(3'h3, {16'hfdf8, 8'ha7, 8'h00, 8'h1c});
    for (int c = 2; c <= 10; c++) begin
      if (c != 3) begin
        wr(8'h08, {4'hb, c[3:0], 24'h15_3ca7});
        tx_one(3'h4, {20'hfdf91, 4'h0, c[3:0], 4'hb, 8'h00});
      end
    end
    chk(peer_skew, 40'h0);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_rx();
    logic e;
    logic [39:0] a [9] = '{40'hfdfe_009ab4, 40'hfdff_129ab4, 40'hfdff_12ff00, 40'hfdf8_410308,
      40'hfdf8_41001c, 40'hfdf9_156a00, 40'hfdf9_102100, 40'hfdf9_10a100, 40'h1234_000000};
    logic [2:0] kd [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h4, 3'h4, 3'h4, 3'h6};
    int bt [9] = '{1, 1, 2, 3, 4, 5, 5, 5, 6};
    logic [31:0] sm [9] = '{0, 0, 0, 0, 0, 32'h73f, 32'h1f, 32'h2f, 0};
    logic [31:0] se [9] = '{0, 0, 0, 0, 0, 32'h506, 32'h12, 32'h2a, 0};
    for (int i = 0; i < 9; i++) begin
      i_lsae_peer.send(a[i]);
      wait_stat(bt[i]);
      rdc(8'h10, a[i][31:0]);
      rdc(8'h14, {21'h0, kd[i], a[i][39:32]});
      apb(1'b0, 8'h24, 32'h0, rd, e);
      if (sm[i] != 0) chk(rd & sm[i], se[i]);
      wr(8'h18, 32'hff);
    end
    i_lsae_peer.send(40'hfdfe_00ffff, 2);
    wait_stat(6);
    rdc(8'h14, {21'h0, 3'h6, 8'h12});
    wr(8'h18, 32'hff);
    i_lsae_peer.send(a[0]);
    wait_stat(1);
    rdc(8'h10, a[0][31:0]);
    $display("test receive done");
  endtask : t_rx

  task automatic t_side();
    int f;
    @(posedge mclk_i);
    power_good_i <= 1'b0;
    wait_stat(7);
    rdc(8'h20, 32'h0e);
    power_good_i <= 1'b1;
    wr(8'h00, 32'h3);
    repeat (4) @(posedge mclk_i);
    chk({stop_oe, req_oe}, 2'b11);
    rdc(8'h20, 32'h03);
    wr(8'h00, 32'h0);
    link_reset_n_i <= 1'b0;
    wr(8'h00, 32'h4);
    repeat (4) @(posedge mclk_i);
    f = peer_frames;
    wr(8'h0c, 32'h0);
    repeat (60) @(posedge mclk_i);
    chk(peer_frames, f);
    rdc(8'h20, 32'h0d);
    link_reset_n_i <= 1'b1;
    $display("test sideband done");
  endtask : t_side

  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_side();
    end_sim();
  end
endmodule : test_lsae_top
